// file: include/cwfr_pkg.sv
// Constants, types and structs of the cyclic watch and fault report block
package cwfr_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned WATCH_STEP_MS = 100;
  localparam int unsigned WATCH_STEP_CYC = CLK_HZ / 1000 * WATCH_STEP_MS;
  localparam int unsigned WARN_CLR_S    = 5;
  localparam int unsigned WARN_CLR_CYC  = CLK_HZ * WARN_CLR_S;
  localparam int unsigned FLASH_MS      = 500;
  localparam int unsigned FLASH_CYC     = CLK_HZ / 1000 * FLASH_MS;

  // ----------------------------------------
  // Widths and field values
  // ----------------------------------------
  localparam int unsigned SET_W      = 5;
  localparam logic [4:0]  WATCH_OFF  = 5'h00;
  localparam logic [4:0]  WATCH_MAX  = 5'h14;
  localparam int unsigned CODE_W     = 16;
  localparam int unsigned ADDR_W     = 16;
  localparam int unsigned PV_W       = 16;
  localparam int unsigned CNT_W      = 32;
  localparam int unsigned N_ALM      = 11;
  localparam int unsigned N_ALERT    = 6;
  localparam logic [15:0] CODE_NONE  = 16'h0000;
  localparam logic [15:0] ALM_BASE   = 16'h0a00;

  // Alarm bit positions
  localparam int unsigned ALM_PV_HI  = 0;
  localparam int unsigned ALM_PV_LO  = 1;
  localparam int unsigned ALM_LOOP   = 2;
  localparam int unsigned ALM_ALERT0 = 3;
  localparam int unsigned ALM_RATE_U = 9;
  localparam int unsigned ALM_RATE_D = 10;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {
    CWFR_HOLD  = 1'b0,
    CWFR_CLEAR = 1'b1
  } cwfr_policy_t;

  typedef enum logic [1:0] {
    CWFR_LED_OFF   = 2'b00,
    CWFR_LED_FLASH = 2'b01,
    CWFR_LED_ON    = 2'b10
  } cwfr_led_t;

  typedef struct packed {
    logic              valid;
    logic              hw_fail;
    logic [CODE_W-1:0] code;
    logic [ADDR_W-1:0] addr;
  } cwfr_fault_t;

  typedef struct packed {
    logic signed [PV_W-1:0] lo;
    logic signed [PV_W-1:0] hi;
  } cwfr_lim_t;
endpackage

// file: rtl/cwfr_watch.sv
// Cyclic refresh watch timer in steps of one tenth of a second
`timescale 1ns/1ps
module cwfr_watch #(
  parameter int unsigned STEP_CYC = cwfr_pkg::WATCH_STEP_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        refresh,
  input  wire logic [cwfr_pkg::SET_W-1:0]  setting,
  output logic                             timeout
);
  logic [cwfr_pkg::CNT_W-1:0] cyc_r;
  logic [cwfr_pkg::SET_W-1:0] step_r;
  logic [cwfr_pkg::SET_W-1:0] limit;

  // Settings above the top of the range act as the top
  assign limit = (setting > cwfr_pkg::WATCH_MAX) ? cwfr_pkg::WATCH_MAX : setting;

  // ----------------------------------------
  // Interval count
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r   <= '0;
      step_r  <= '0;
      timeout <= 1'b0;
    end else if (refresh || limit == cwfr_pkg::WATCH_OFF) begin
      cyc_r   <= '0;
      step_r  <= '0;
      timeout <= 1'b0;
    end else if (!timeout) begin
      if (cyc_r == STEP_CYC - 1) begin
        cyc_r  <= '0;
        step_r <= step_r + 5'h01;
        if (step_r + 5'h01 >= limit) begin
          timeout <= 1'b1;
        end
      end else begin
        cyc_r <= cyc_r + 32'h0000_0001;
      end
    end
  end
endmodule

// file: rtl/cwfr_delay.sv
// Release delay that fires once after its run level stays high long enough
`timescale 1ns/1ps
module cwfr_delay #(
  parameter int unsigned DLY_CYC = cwfr_pkg::WARN_CLR_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);
  logic [cwfr_pkg::CNT_W-1:0] cnt_r;
  logic                       fired_r;

  // ----------------------------------------
  // Count while run stays high
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r   <= '0;
      fired_r <= 1'b0;
      done    <= 1'b0;
    end else if (!run) begin
      cnt_r   <= '0;
      fired_r <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!fired_r) begin
        if (cnt_r == DLY_CYC - 1) begin
          done    <= 1'b1;
          fired_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 32'h0000_0001;
        end
      end
    end
  end
endmodule

// file: rtl/cwfr_top.sv
// Cyclic update watch, output policy and fault/warning reporting
//
// Summary of operation
// - Time gaps between cyclic refreshes; on timeout apply hold or clear policy.
// - Watch setting 0 disables; 1 to 20 give 100 ms steps.
// - Hold or clear comes from the CPU stop error output policy input.
// - Link indicator flashes when link up but cyclic stopped, off when no link.
// - Serious fault flag rises on any moderate or major error.
// - Serious error code stored in fault code word, except hardware failures.
// - Faulting buffer memory address stored in fault location word.
// - Minor fault flag rises on any minor error.
// - Minor error or alarm code stored in last warning code word.
// - Five seconds after warning cause ends: code zero; flag off unless an alarm is active, indicator off unless a serious fault is.
// - Range over and under alarms clear when value returns inside input range.
// - Loop break alarm clears when its cause is gone.
// - Four alerts and process alarm limits clear inside their alert window.
// - Rate alarms clear when the change is back within the rate limit.
// - Warning code clears to zero on warning removal despite live alarms.
`timescale 1ns/1ps
module cwfr_top #(
  parameter int unsigned OUT_W     = 8,
  parameter int unsigned STEP_CYC  = cwfr_pkg::WATCH_STEP_CYC,
  parameter int unsigned CLR_CYC   = cwfr_pkg::WARN_CLR_CYC,
  parameter int unsigned FLASH_CYC = cwfr_pkg::FLASH_CYC
) (
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst_n,
  input  wire logic                                  cyc_refresh,
  input  wire logic                                  link_up,
  input  wire logic [cwfr_pkg::SET_W-1:0]            watch_setting,
  input  wire cwfr_pkg::cwfr_policy_t                out_policy,
  input  wire logic [OUT_W-1:0]                      ctrl_in,
  input  wire cwfr_pkg::cwfr_fault_t                 fault_evt,
  input  wire logic                                  fault_clear,
  input  wire logic                                  warn_evt,
  input  wire logic [cwfr_pkg::CODE_W-1:0]           warn_code,
  input  wire logic                                  warn_cause,
  input  wire logic signed [cwfr_pkg::PV_W-1:0]      process_value,
  input  wire logic signed [cwfr_pkg::PV_W-1:0]      pv_delta,
  input  wire logic [cwfr_pkg::PV_W-1:0]             rate_limit,
  input  wire cwfr_pkg::cwfr_lim_t                   input_range,
  input  wire cwfr_pkg::cwfr_lim_t [5:0]             alert_lim,
  input  wire logic                                  loop_break,
  output logic [OUT_W-1:0]                           ctrl_out,
  output logic                                       run_active,
  output logic                                       watch_timeout,
  output logic                                       link_state_indicator,
  output logic                                       serious_fault_flag,
  output logic [cwfr_pkg::CODE_W-1:0]                last_fault_code_word,
  output logic [cwfr_pkg::ADDR_W-1:0]                fault_location_word,
  output logic                                       minor_fault_flag,
  output logic [cwfr_pkg::CODE_W-1:0]                last_warning_code_word,
  output logic [cwfr_pkg::N_ALM-1:0]                 alarm_state,
  output logic                                       fault_indicator
);
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic out_of(input logic signed [15:0] v, input cwfr_pkg::cwfr_lim_t l);
    out_of = (v > l.hi) || (v < l.lo);
  endfunction

  function automatic logic [15:0] alm_code(input logic [10:0] rise);
    alm_code = cwfr_pkg::CODE_NONE;
    for (int i = cwfr_pkg::N_ALM - 1; i >= 0; i--) begin
      if (rise[i]) begin
        alm_code = cwfr_pkg::ALM_BASE + 16'(i);
      end
    end
  endfunction

  // ----------------------------------------
  // Cyclic update watch
  // ----------------------------------------
  logic tmo;
  logic warn_rel;
  logic warn_r;
  logic flash_r;
  logic [cwfr_pkg::CNT_W-1:0] flash_cnt_r;
  cwfr_pkg::cwfr_led_t led_state;
  logic [cwfr_pkg::N_ALM-1:0] alm_nxt;
  logic signed [cwfr_pkg::PV_W:0] lim_s;

  cwfr_watch #(
    .STEP_CYC (STEP_CYC)
  ) u_watch (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .refresh  (cyc_refresh),
    .setting  (watch_setting),
    .timeout  (tmo)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      watch_timeout <= 1'b0;
      ctrl_out      <= '0;
      run_active    <= 1'b1;
    end else begin
      watch_timeout <= tmo;
      if (tmo && out_policy == cwfr_pkg::CWFR_CLEAR) begin
        ctrl_out   <= '0;
        run_active <= 1'b0;
      end else if (!tmo) begin
        ctrl_out   <= ctrl_in;
        run_active <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Link state indicator
  // ----------------------------------------
  always_comb begin
    if (!link_up) begin
      led_state = cwfr_pkg::CWFR_LED_OFF;
    end else if (tmo) begin
      led_state = cwfr_pkg::CWFR_LED_FLASH;
    end else begin
      led_state = cwfr_pkg::CWFR_LED_ON;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flash_cnt_r <= '0;
      flash_r     <= 1'b0;
    end else if (flash_cnt_r == FLASH_CYC - 1) begin
      flash_cnt_r <= '0;
      flash_r     <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_state_indicator <= 1'b0;
    end else begin
      unique case (led_state)
        cwfr_pkg::CWFR_LED_OFF:   link_state_indicator <= 1'b0;
        cwfr_pkg::CWFR_LED_FLASH: link_state_indicator <= flash_r;
        cwfr_pkg::CWFR_LED_ON:    link_state_indicator <= 1'b1;
        default:                  link_state_indicator <= 1'b0;
      endcase
    end
  end

  // ----------------------------------------
  // Serious fault report
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      serious_fault_flag   <= 1'b0;
      last_fault_code_word <= cwfr_pkg::CODE_NONE;
      fault_location_word  <= '0;
    end else if (fault_evt.valid) begin
      serious_fault_flag  <= 1'b1;
      fault_location_word <= fault_evt.addr;
      if (!fault_evt.hw_fail) begin
        last_fault_code_word <= fault_evt.code;
      end
    end else if (fault_clear) begin
      serious_fault_flag   <= 1'b0;
      last_fault_code_word <= cwfr_pkg::CODE_NONE;
    end
  end

  // ----------------------------------------
  // Alarm evaluation
  // ----------------------------------------
  assign lim_s = {1'b0, rate_limit};

  always_comb begin
    alm_nxt = '0;
    alm_nxt[cwfr_pkg::ALM_PV_HI] = process_value > input_range.hi;
    alm_nxt[cwfr_pkg::ALM_PV_LO] = process_value < input_range.lo;
    alm_nxt[cwfr_pkg::ALM_LOOP]  = loop_break;
    for (int k = 0; k < cwfr_pkg::N_ALERT; k++) begin
      alm_nxt[cwfr_pkg::ALM_ALERT0 + k] = out_of(process_value, alert_lim[k]);
    end
    alm_nxt[cwfr_pkg::ALM_RATE_U] = 17'(pv_delta) > lim_s;
    alm_nxt[cwfr_pkg::ALM_RATE_D] = 17'(pv_delta) < -lim_s;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_state <= '0;
    end else begin
      alarm_state <= alm_nxt;
    end
  end

  // ----------------------------------------
  // Warning report and release
  // ----------------------------------------
  cwfr_delay #(
    .DLY_CYC (CLR_CYC)
  ) u_release (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .run     (warn_r && !warn_cause && !warn_evt),
    .done    (warn_rel)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_r                 <= 1'b0;
      last_warning_code_word <= cwfr_pkg::CODE_NONE;
    end else if (warn_evt) begin
      warn_r                 <= 1'b1;
      last_warning_code_word <= warn_code;
    end else if (|(alm_nxt & ~alarm_state)) begin
      last_warning_code_word <= alm_code(alm_nxt & ~alarm_state);
    end else if (warn_rel) begin
      warn_r                 <= 1'b0;
      last_warning_code_word <= cwfr_pkg::CODE_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      minor_fault_flag <= 1'b0;
      fault_indicator  <= 1'b0;
    end else begin
      minor_fault_flag <= (warn_r && !warn_rel) || warn_evt || (|alm_nxt);
      fault_indicator  <= (warn_r && !warn_rel) || warn_evt || serious_fault_flag;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_clear_tmo;
    tmo && out_policy == cwfr_pkg::CWFR_CLEAR;
  endsequence

  sequence s_hold_tmo;
    tmo && out_policy == cwfr_pkg::CWFR_HOLD;
  endsequence

  chk_clear_outputs: assert property (s_clear_tmo |=> ctrl_out == '0 && !run_active)
    else $error("outputs not cleared on watch timeout");
  chk_hold_outputs: assert property (s_hold_tmo ##1 tmo |=> $stable(ctrl_out))
    else $error("outputs not held on watch timeout");
  chk_watch_off: assert property (watch_setting == cwfr_pkg::WATCH_OFF |=> !tmo)
    else $error("watch ran while disabled");
  chk_refresh_restart: assert property (cyc_refresh |=> !tmo)
    else $error("timeout right after a refresh");
  chk_led_nolink: assert property (!link_up |=> !link_state_indicator)
    else $error("link indicator lit without link");
  chk_serious_flag: assert property (fault_evt.valid |=>
      serious_fault_flag && fault_location_word == $past(fault_evt.addr))
    else $error("serious fault not reported");
  chk_hw_code: assert property (fault_evt.valid && fault_evt.hw_fail |=> $stable(last_fault_code_word))
    else $error("hardware failure code was recorded");
  chk_warn_code: assert property (warn_evt |=> minor_fault_flag && last_warning_code_word == $past(warn_code))
    else $error("warning not reported");
  chk_warn_release: assert property (warn_rel && !warn_evt && !(|(alm_nxt & ~alarm_state)) |=>
      last_warning_code_word == cwfr_pkg::CODE_NONE && !warn_r)
    else $error("warning not released");
  chk_rate_clear: assert property (17'(pv_delta) <= lim_s && 17'(pv_delta) >= -lim_s |=>
      !alarm_state[cwfr_pkg::ALM_RATE_U] && !alarm_state[cwfr_pkg::ALM_RATE_D])
    else $error("rate alarm stayed on");

  sequence s_range_ok;
    process_value <= input_range.hi && process_value >= input_range.lo;
  endsequence

  sequence s_alert_ok;
    process_value <= alert_lim[5].hi && process_value >= alert_lim[5].lo;
  endsequence

  sequence s_warn_live;
    warn_r && warn_cause && !warn_rel;
  endsequence

  chk_timeout_flag: assert property (tmo |=> watch_timeout)
    else $error("timeout flag not raised");
  chk_run_resume: assert property (!tmo |=> run_active && ctrl_out == $past(ctrl_in))
    else $error("outputs do not follow control input");
  chk_led_on: assert property (link_up && !tmo |=> link_state_indicator)
    else $error("link indicator dark while link is up");
  chk_fault_lamp: assert property (serious_fault_flag |=> fault_indicator)
    else $error("fault indicator dark during serious fault");
  chk_fault_code: assert property (fault_evt.valid && !fault_evt.hw_fail |=>
      last_fault_code_word == $past(fault_evt.code))
    else $error("fault code not recorded");
  chk_minor_flag: assert property (warn_evt || (|alm_nxt) |=> minor_fault_flag)
    else $error("minor fault flag not raised");
  chk_alarm_code: assert property (!warn_evt && (|(alm_nxt & ~alarm_state)) |=>
      last_warning_code_word != cwfr_pkg::CODE_NONE)
    else $error("alarm code not recorded");
  chk_warn_stays: assert property (s_warn_live |=> warn_r)
    else $error("warning released while its cause is present");
  chk_range_clear: assert property (s_range_ok |=>
      !alarm_state[cwfr_pkg::ALM_PV_HI] && !alarm_state[cwfr_pkg::ALM_PV_LO])
    else $error("range alarm stayed on");
  chk_loop_clear: assert property (!loop_break |=> !alarm_state[cwfr_pkg::ALM_LOOP])
    else $error("loop alarm stayed on");
  chk_alert_clear: assert property (s_alert_ok |=> !alarm_state[cwfr_pkg::ALM_ALERT0 + 5])
    else $error("alert alarm stayed on");
endmodule

// file: tb/cwfr_master_model.sv
// Master station model that sends cyclic refresh pulses over the link
`timescale 1ns/1ps
module cwfr_master_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       send,
  input  wire logic [7:0] gap,
  input  wire logic       link_req,
  output logic            cyc_refresh,
  output logic            link_up
);
  logic [7:0] cnt_r;

  // ----------------------------------------
  // Refresh pulses, one every gap cycles
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= 8'h00;
      cyc_refresh <= 1'b0;
    end else if (!send) begin
      cnt_r       <= 8'h00;
      cyc_refresh <= 1'b0;
    end else if (cnt_r == 8'h00) begin
      cnt_r       <= gap - 8'h01;
      cyc_refresh <= 1'b1;
    end else begin
      cnt_r       <= cnt_r - 8'h01;
      cyc_refresh <= 1'b0;
    end
  end

  assign link_up = link_req;
endmodule

// file: tb/cwfr_top_tb.sv
// Self-checking testbench of the cyclic watch and fault report block
`timescale 1ns/1ps
module cwfr_top_tb;
  typedef struct {int due; int sel; logic [15:0] exp;} cwfr_note_t;
  logic                      ref_clk, rst_n, send, link_req, cyc_refresh, link_up;
  logic [7:0]                gap, ctrl_in, ctrl_out, held;
  logic [4:0]                watch_setting;
  cwfr_pkg::cwfr_policy_t    out_policy;
  cwfr_pkg::cwfr_fault_t     fault_evt;
  logic                      fault_clear, warn_evt, warn_cause, loop_break;
  logic [15:0]               warn_code, rate_limit, v;
  logic signed [15:0]        process_value, pv_delta;
  cwfr_pkg::cwfr_lim_t       input_range;
  cwfr_pkg::cwfr_lim_t [5:0] alert_lim;
  logic                      run_active, watch_timeout, link_state_indicator;
  logic                      serious_fault_flag, minor_fault_flag, fault_indicator;
  logic [15:0]               last_fault_code_word, fault_location_word, last_warning_code_word;
  logic [10:0]               alarm_state;
  int                        cyc = 0, bad_count = 0, checked = 0, seed, k, ones;
  cwfr_note_t                notes[$];
  string nm[11] = '{"watch_timeout", "ctrl_out", "run_active", "link_state_indicator", "serious_fault_flag",
                    "last_fault_code_word", "fault_location_word", "minor_fault_flag",
                    "last_warning_code_word", "alarm_state", "fault_indicator"};
  logic [15:0] tp[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0096, 16'hff38};
  logic [15:0] td[6] = '{16'h0032, 16'h0033, 16'hffcd, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] te[6] = '{16'h0000, 16'h0200, 16'h0400, 16'h0004, 16'h0008, 16'h0100};

  cwfr_master_model i_master (.ref_clk(ref_clk), .rst_n(rst_n), .send(send), .gap(gap), .link_req(link_req),
                              .cyc_refresh(cyc_refresh), .link_up(link_up));

  cwfr_top #(.OUT_W(8), .STEP_CYC(4), .CLR_CYC(10), .FLASH_CYC(2)) i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cyc_refresh(cyc_refresh), .link_up(link_up),
    .watch_setting(watch_setting), .out_policy(out_policy), .ctrl_in(ctrl_in), .fault_evt(fault_evt),
    .fault_clear(fault_clear), .warn_evt(warn_evt), .warn_code(warn_code), .warn_cause(warn_cause),
    .process_value(process_value), .pv_delta(pv_delta), .rate_limit(rate_limit), .input_range(input_range),
    .alert_lim(alert_lim), .loop_break(loop_break), .ctrl_out(ctrl_out), .run_active(run_active),
    .watch_timeout(watch_timeout), .link_state_indicator(link_state_indicator),
    .serious_fault_flag(serious_fault_flag), .last_fault_code_word(last_fault_code_word),
    .fault_location_word(fault_location_word), .minor_fault_flag(minor_fault_flag),
    .last_warning_code_word(last_warning_code_word), .alarm_state(alarm_state), .fault_indicator(fault_indicator));

  // ----------------------------------------
  // Clock, checking and verdict
  // ----------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] obs(input int sel);
    case (sel)
      0: obs = 16'(watch_timeout);
      1: obs = 16'(ctrl_out);
      2: obs = 16'(run_active);
      3: obs = 16'(link_state_indicator);
      4: obs = 16'(serious_fault_flag);
      5: obs = last_fault_code_word;
      6: obs = fault_location_word;
      7: obs = 16'(minor_fault_flag);
      8: obs = last_warning_code_word;
      9: obs = 16'(alarm_state);
      default: obs = 16'(fault_indicator);
    endcase
  endfunction

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic note(input int sel, input logic [15:0] exp, input int dly);
    notes.push_back('{cyc + dly, sel, exp});
  endtask

  always @(posedge ref_clk) cyc <= cyc + 1;

  always @(negedge ref_clk) begin
    for (int i = notes.size() - 1; i >= 0; i--) begin
      if (notes[i].due == cyc) begin
        check(nm[notes[i].sel], obs(notes[i].sel), notes[i].exp);
        notes.delete(i);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge ref_clk);
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    seed = 86;
    rst_n = 1'b0;
    send = 1'b0;
    gap = 8'h03;
    link_req = 1'b1;
    watch_setting = 5'h00;
    out_policy = cwfr_pkg::CWFR_HOLD;
    ctrl_in = 8'h00;
    fault_evt = '0;
    fault_clear = 1'b0;
    warn_evt = 1'b0;
    warn_code = 16'h0000;
    warn_cause = 1'b0;
    loop_break = 1'b0;
    process_value = 16'h0000;
    pv_delta = 16'h0000;
    rate_limit = 16'h0032;
    input_range = '{16'hfc18, 16'h03e8};
    for (int i = 0; i < 6; i++) alert_lim[i] = '{16'h8ad0, 16'h7530};
    alert_lim[0].hi = 16'h0064;
    alert_lim[5].lo = 16'hff9c;
    tick(6);
    rst_n = 1'b1;
    note(0, 16'h0000, 0);
    note(2, 16'h0001, 0);
    note(4, 16'h0000, 0);
    for (int i = 0; i < 3; i++) begin
      k = (i == 0) ? 1 : (i == 1) ? 2 : 20;
      watch_setting = (i == 2) ? 5'h1f : 5'(k);
      out_policy = cwfr_pkg::cwfr_policy_t'(i[0]);
      held = 8'($random(seed));
      ctrl_in = held;
      send = 1'b1;
      tick(1);
      send = 1'b0;
      note(0, 16'h0000, 4 * k + 1);
      note(0, 16'h0001, 4 * k + 3);
      note(2, 16'(!i[0]), 4 * k + 3);
      tick(4 * k + 3);
      ones = 0;
      repeat (4) begin
        ones += int'(link_state_indicator);
        tick(1);
      end
      check("link_flash", 16'(ones), 16'h0002);
      ctrl_in = ~held;
      note(1, i[0] ? 16'h0000 : 16'(held), 2);
      link_req = 1'b0;
      note(3, 16'h0000, 2);
      tick(3);
      link_req = 1'b1;
      send = 1'b1;
      tick(12);
      note(0, 16'h0000, 0);
      note(3, 16'h0001, 0);
    end
    send = 1'b0;
    watch_setting = 5'h00;
    tick(100);
    note(0, 16'h0000, 0);
    v = 16'($random(seed));
    fault_evt = '{1'b1, 1'b0, v, 16'h0123};
    note(4, 16'h0001, 1);
    note(10, 16'h0001, 2);
    tick(1);
    fault_evt = '{1'b1, 1'b1, 16'h7777, 16'h0456};
    note(5, v, 1);
    note(6, 16'h0456, 1);
    tick(1);
    fault_evt = '0;
    fault_clear = 1'b1;
    note(4, 16'h0000, 1);
    tick(1);
    fault_clear = 1'b0;
    process_value = 16'h07d0;
    tick(3);
    note(9, 16'h0009, 0);
    note(8, 16'h0a00, 0);
    warn_code = 16'h0140;
    warn_evt = 1'b1;
    warn_cause = 1'b1;
    note(7, 16'h0001, 1);
    note(8, 16'h0140, 1);
    tick(1);
    warn_evt = 1'b0;
    tick(3);
    warn_cause = 1'b0;
    note(8, 16'h0140, 10);
    note(8, 16'h0000, 14);
    note(10, 16'h0000, 14);
    tick(15);
    process_value = 16'h0000;
    note(9, 16'h0000, 2);
    tick(3);
    for (int i = 0; i < 6; i++) begin
      process_value = tp[i];
      pv_delta = td[i];
      loop_break = (i == 3);
      note(9, te[i], 2);
      tick(3);
      process_value = 16'h0000;
      pv_delta = 16'h0000;
      loop_break = 1'b0;
      note(9, 16'h0000, 2);
      tick(3);
    end
    tick(4);
    print_verdict();
  end
endmodule
